// ===== sbcfg_cfg.svh
`ifndef SBCFG_CFG_SVH
`define SBCFG_CFG_SVH

// ----------------------------------------
// Command codes and lengths
// ----------------------------------------
`define CMD_DS_RD        8'h61
`define CMD_LOC_RD       8'he1
`define WL_DS_RD         8'h06
`define WL_LOC_RD        8'h05
`define RL_DWORD         8'h05
`define RL_WORD          8'h03
`define RL_BYTE          8'h02

// ----------------------------------------
// Completion codes
// ----------------------------------------
`define CC_PASS          8'h40
`define CC_LATE          8'h80
`define CC_BUSY          8'h81
`define CC_ASLEEP        8'h82
`define CC_INVALID       8'h90
`define CC_BROKEN        8'h91

// ----------------------------------------
// Address fields
// ----------------------------------------
`define DS_RSV_HI        31
`define DS_RSV_LO        28
`define DS_BUS_HI        27
`define DS_BUS_LO        20
`define LOC_BUS_HI       23
`define LOC_BUS_LO       20
`define DEV_HI           19
`define DEV_LO           15
`define FUNC_HI          14
`define FUNC_LO          12
`define REG_HI           11
`define REG_LO           0
`define LAST_LOCAL_BUS   8'h01
`define BUS1_FIRST_DEV   5'h08
`define BUS1_LAST_DEV    5'h0f
`define BUS0_LAST_DEV    5'h07

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS    25
`define RSP_TIMEOUT_NS   50000
`define RSP_TIMEOUT_CYC  (`RSP_TIMEOUT_NS / `CLK_PERIOD_NS)
`endif

// ===== sbcfg_pkg.sv
package sbcfg_pkg;
  typedef struct packed {
    logic [7:0] wl;
    logic [7:0] rl;
  } frame_hdr_s;

  typedef struct packed {
    logic        downstream;
    logic        internal;
    logic [7:0]  bus;
    logic [4:0]  dev;
    logic [2:0]  func;
    logic [11:0] offset;
    logic [7:0]  rl;
  } cfg_req_s;

  typedef enum logic [2:0] {
    rsp_ok,
    rsp_busy,
    rsp_asleep,
    rsp_broken,
    rsp_invalid
  } rsp_status_e;

  typedef struct packed {
    rsp_status_e status;
    logic [31:0] data;
  } cfg_rsp_s;

  typedef enum logic [2:0] {
    st_idle,
    st_collect,
    st_check,
    st_issue,
    st_wait,
    st_reply,
    st_drain
  } svc_state_e;
endpackage

// ===== cfg_addr_decode.sv
`include "sbcfg_cfg.svh"
module cfg_addr_decode
  import sbcfg_pkg::*;
(
  input  wire logic [31:0] addr,
  input  wire logic        downstream,
  input  wire logic [7:0]  rl,
  output cfg_req_s         req,
  output logic             rsv_bad,
  output logic             bus_bad
);
  function automatic logic is_internal(input logic [7:0] bus, input logic [4:0] dev);
    is_internal = ((bus == 8'h00) && (dev <= `BUS0_LAST_DEV)) ||
                  ((bus == 8'h01) && (dev >= `BUS1_FIRST_DEV) && (dev <= `BUS1_LAST_DEV));
  endfunction

  always_comb begin
    req.downstream = downstream;
    req.rl         = rl;
    req.dev        = addr[`DEV_HI:`DEV_LO];
    req.func       = addr[`FUNC_HI:`FUNC_LO];
    req.offset     = addr[`REG_HI:`REG_LO];
    if (downstream) begin
      req.bus = addr[`DS_BUS_HI:`DS_BUS_LO];
    end else begin
      req.bus = {4'h0, addr[`LOC_BUS_HI:`LOC_BUS_LO]};
    end
    req.internal = is_internal(req.bus, req.dev);
    rsv_bad      = downstream && (addr[`DS_RSV_HI:`DS_RSV_LO] != 4'h0);
    // Local space maps buses 0 and 1 only; any other bus number is dropped
    bus_bad      = !downstream && (req.bus > `LAST_LOCAL_BUS);
  end
endmodule

// ===== reply_serializer.sv
module reply_serializer (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        load,
  input  wire logic [7:0]  cc,
  input  wire logic [31:0] data,
  input  wire logic [2:0]  nbytes,
  input  wire logic        tx_ready,
  output logic             tx_valid_ff,
  output logic [7:0]       tx_byte_ff,
  output logic             tx_last_ff,
  output logic             busy
);
  logic [39:0] shift_ff;
  logic [39:0] nxt_shift;
  logic [2:0]  left_ff;
  logic [2:0]  nxt_left;
  logic        nxt_valid;
  logic [7:0]  nxt_byte;
  logic        nxt_last;

  assign busy = tx_valid_ff || (left_ff != 3'h0);

  always_comb begin
    nxt_shift = shift_ff;
    nxt_left  = left_ff;
    nxt_valid = tx_valid_ff;
    nxt_byte  = tx_byte_ff;
    nxt_last  = tx_last_ff;
    if (load) begin
      nxt_shift = {data, cc};
      nxt_left  = nbytes;
      nxt_valid = 1'b0;
    end else if (!tx_valid_ff || tx_ready) begin
      nxt_valid = left_ff != 3'h0;
      nxt_byte  = shift_ff[7:0];
      nxt_last  = left_ff == 3'h1;
      nxt_shift = {8'h00, shift_ff[39:8]};
      if (left_ff != 3'h0) begin
        nxt_left = left_ff - 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_ff    <= 40'h0;
      left_ff     <= 3'h0;
      tx_valid_ff <= 1'b0;
      tx_byte_ff  <= 8'h00;
      tx_last_ff  <= 1'b0;
    end else begin
      shift_ff    <= nxt_shift;
      left_ff     <= nxt_left;
      tx_valid_ff <= nxt_valid;
      tx_byte_ff  <= nxt_byte;
      tx_last_ff  <= nxt_last;
    end
  end
endmodule

// ===== sideband_config_read_service.sv
`include "sbcfg_cfg.svh"
module sideband_config_read_service
  import sbcfg_pkg::*;
#(
  parameter int unsigned RSP_TIMEOUT_CYC = `RSP_TIMEOUT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Frame from the link layer
  input  wire logic       frame_start,
  input  wire frame_hdr_s frame_hdr,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_last,
  input  wire logic       rx_check_bad,
  // Reply toward the link layer
  output logic            tx_valid,
  output logic [7:0]      tx_byte,
  output logic            tx_last,
  input  wire logic       tx_ready,
  output logic            tx_abort,
  // Condition of the serving hardware
  input  wire logic       target_asleep,
  input  wire logic       ctrl_fault,
  input  wire logic       no_resources,
  // Configuration access toward the targets
  output logic            cfg_req_valid,
  output cfg_req_s        cfg_req,
  input  wire logic       cfg_req_ready,
  input  wire logic       cfg_rsp_valid,
  input  wire cfg_rsp_s   cfg_rsp,
  output logic            svc_busy
);
  localparam logic [15:0] TIMEOUT_LIMIT = 16'(RSP_TIMEOUT_CYC);

  // ----------------------------------------
  // Frame legality
  // ----------------------------------------
  function automatic logic combo_ok(input logic [7:0] cmd, input frame_hdr_s h);
    logic ds_ok;
    logic loc_ok;
    ds_ok  = (cmd == `CMD_DS_RD) && (h.wl == `WL_DS_RD) && (h.rl == `RL_DWORD);
    loc_ok = (cmd == `CMD_LOC_RD) && (h.wl == `WL_LOC_RD) &&
             ((h.rl == `RL_BYTE) || (h.rl == `RL_WORD) || (h.rl == `RL_DWORD));
    combo_ok = ds_ok || loc_ok;
  endfunction

  function automatic logic [7:0] status_cc(input rsp_status_e s);
    unique case (s)
      rsp_ok:      status_cc = `CC_PASS;
      rsp_busy:    status_cc = `CC_BUSY;
      rsp_asleep:  status_cc = `CC_ASLEEP;
      rsp_broken:  status_cc = `CC_BROKEN;
      rsp_invalid: status_cc = `CC_INVALID;
      default:     status_cc = `CC_BROKEN;
    endcase
  endfunction

  function automatic logic [31:0] size_mask(input logic [7:0] rl, input logic [31:0] d);
    if (rl == `RL_BYTE) begin
      size_mask = {24'h0, d[7:0]};
    end else if (rl == `RL_WORD) begin
      size_mask = {16'h0, d[15:0]};
    end else begin
      size_mask = d;
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  svc_state_e  state_ff;
  svc_state_e  nxt_state;
  logic [2:0]  idx_ff;
  logic [2:0]  nxt_idx;
  logic [7:0]  cmd_ff;
  logic [7:0]  nxt_cmd;
  frame_hdr_s  hdr_ff;
  frame_hdr_s  nxt_hdr;
  logic [31:0] addr_ff;
  logic [31:0] nxt_addr;
  cfg_req_s    req_ff;
  cfg_req_s    nxt_req;
  logic        req_valid_ff;
  logic        nxt_req_valid;
  logic [15:0] timer_ff;
  logic [15:0] nxt_timer;
  logic [7:0]  cc_ff;
  logic [7:0]  nxt_cc;
  logic [31:0] data_ff;
  logic [31:0] nxt_data;
  logic        load_ff;
  logic        nxt_load;
  logic        abort_ff;
  logic        nxt_abort;
  logic        busy_ff;
  logic        nxt_busy;

  logic        is_ds;
  logic [31:0] dec_addr;
  cfg_req_s    dec_req;
  logic        rsv_bad;
  logic        bus_bad;
  logic        ser_busy;

  assign is_ds    = cmd_ff == `CMD_DS_RD;
  // Local address is three bytes, so it sits one byte high in the shifter
  assign dec_addr = is_ds ? addr_ff : {8'h00, addr_ff[31:8]};

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  cfg_addr_decode u_decode (
    .addr       (dec_addr),
    .downstream (is_ds),
    .rl         (hdr_ff.rl),
    .req        (dec_req),
    .rsv_bad    (rsv_bad),
    .bus_bad    (bus_bad)
  );

  reply_serializer u_reply (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .load        (load_ff),
    .cc          (cc_ff),
    .data        (data_ff),
    .nbytes      (hdr_ff.rl[2:0]),
    .tx_ready    (tx_ready),
    .tx_valid_ff (tx_valid),
    .tx_byte_ff  (tx_byte),
    .tx_last_ff  (tx_last),
    .busy        (ser_busy)
  );

  // ----------------------------------------
  // Check-cycle and timeout conditions
  // ----------------------------------------
  logic        count_ok;
  logic        frame_ok;
  logic        timed_out;

  // Write length counts every byte after the header, command code included
  assign count_ok  = idx_ff == hdr_ff.wl[2:0];
  assign frame_ok  = combo_ok(cmd_ff, hdr_ff) && count_ok;
  // Counted from the cycle after the check, so the limit is reached one early
  assign timed_out = timer_ff >= TIMEOUT_LIMIT - 16'h1;

  // ----------------------------------------
  // Command sequencing
  // ----------------------------------------
  always_comb begin
    nxt_state     = state_ff;
    nxt_idx       = idx_ff;
    nxt_cmd       = cmd_ff;
    nxt_hdr       = hdr_ff;
    nxt_addr      = addr_ff;
    nxt_req       = req_ff;
    nxt_req_valid = req_valid_ff;
    nxt_timer     = timer_ff;
    nxt_cc        = cc_ff;
    nxt_data      = data_ff;
    nxt_load      = 1'b0;
    nxt_abort     = 1'b0;
    unique case (state_ff)
      st_idle: begin
        // No gating on enumeration state: local reads are served at once
        if (frame_start) begin
          nxt_state = st_collect;
          nxt_hdr   = frame_hdr;
          nxt_idx   = 3'h0;
          nxt_addr  = 32'h0;
        end
      end
      st_collect: begin
        if (rx_valid) begin
          if (idx_ff == 3'h0) begin
            nxt_cmd = rx_byte;
          end else if (idx_ff >= 3'h2) begin
            nxt_addr = {rx_byte, addr_ff[31:8]};
          end
          if (idx_ff != 3'h7) begin
            nxt_idx = idx_ff + 3'h1;
          end
          if (rx_last) begin
            nxt_state = st_check;
          end
        end
      end
      st_check: begin
        nxt_data = 32'h0;
        if (!frame_ok) begin
          nxt_abort = 1'b1;
          nxt_state = st_idle;
        end else begin
          nxt_state = st_reply;
          if (ctrl_fault) begin
            nxt_cc = `CC_BROKEN;
          end else if (target_asleep) begin
            nxt_cc = `CC_ASLEEP;
          end else if (no_resources) begin
            nxt_cc = `CC_BUSY;
          end else if (rsv_bad) begin
            nxt_cc = `CC_INVALID;
          end else if (bus_bad) begin
            nxt_cc = `CC_PASS;
          end else begin
            nxt_req       = dec_req;
            nxt_req_valid = 1'b1;
            nxt_timer     = 16'h0;
            nxt_state     = st_issue;
          end
        end
      end
      st_issue, st_wait: begin
        nxt_timer = timer_ff + 16'h1;
        if (state_ff == st_issue && cfg_req_ready) begin
          nxt_req_valid = 1'b0;
          nxt_state     = st_wait;
        end
        if (state_ff == st_wait && cfg_rsp_valid) begin
          nxt_cc    = status_cc(cfg_rsp.status);
          nxt_data  = size_mask(hdr_ff.rl, cfg_rsp.data);
          nxt_state = st_reply;
        end else if (timed_out) begin
          // A late answer after this point is dropped in idle
          nxt_req_valid = 1'b0;
          nxt_cc        = `CC_LATE;
          nxt_state     = st_reply;
        end
      end
      st_reply: begin
        nxt_load  = 1'b1;
        nxt_state = st_drain;
      end
      st_drain: begin
        if (!ser_busy) begin
          nxt_state = st_idle;
        end
      end
    endcase
    // An electrical error discards the frame being gathered
    if (rx_check_bad && (state_ff == st_collect || state_ff == st_check)) begin
      nxt_state     = st_idle;
      nxt_abort     = 1'b0;
      // A request decoded in the same check cycle must not reach the target
      nxt_req_valid = 1'b0;
    end
    nxt_busy = nxt_state != st_idle;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff     <= st_idle;
      idx_ff       <= 3'h0;
      cmd_ff       <= 8'h00;
      hdr_ff       <= '0;
      addr_ff      <= 32'h0;
      req_ff       <= '0;
      req_valid_ff <= 1'b0;
      timer_ff     <= 16'h0;
      cc_ff        <= 8'h00;
      data_ff      <= 32'h0;
      load_ff      <= 1'b0;
      abort_ff     <= 1'b0;
      busy_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      idx_ff       <= nxt_idx;
      cmd_ff       <= nxt_cmd;
      hdr_ff       <= nxt_hdr;
      addr_ff      <= nxt_addr;
      req_ff       <= nxt_req;
      req_valid_ff <= nxt_req_valid;
      timer_ff     <= nxt_timer;
      cc_ff        <= nxt_cc;
      data_ff      <= nxt_data;
      load_ff      <= nxt_load;
      abort_ff     <= nxt_abort;
      busy_ff      <= nxt_busy;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cfg_req_valid = req_valid_ff;
  assign cfg_req       = req_ff;
  assign tx_abort      = abort_ff;
  assign svc_busy      = busy_ff;
endmodule

// ===== sbcfg_chk.sv
module sbcfg_chk
  import sbcfg_pkg::*;
#(
  parameter int unsigned RSP_TIMEOUT_CYC = 2000
) (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       frame_start,
  input wire frame_hdr_s frame_hdr,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic       rx_last,
  input wire logic       rx_check_bad,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_last,
  input wire logic       tx_ready,
  input wire logic       tx_abort,
  input wire logic       target_asleep,
  input wire logic       ctrl_fault,
  input wire logic       no_resources,
  input wire logic       cfg_req_valid,
  input wire cfg_req_s   cfg_req,
  input wire logic       cfg_req_ready,
  input wire logic       cfg_rsp_valid,
  input wire cfg_rsp_s   cfg_rsp,
  input wire logic       svc_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  // Slack covers collect, check and reply steps around the target wait
  localparam int unsigned WMAX = RSP_TIMEOUT_CYC + 24;
  logic        first_ff;
  logic        nxt_first;
  int unsigned wait_ff;
  int unsigned nxt_wait;
  // ------
  // Helper state
  // ------
  always_comb begin
    nxt_first = first_ff;
    if (frame_start && !svc_busy) nxt_first = 1'b1;
    if (tx_valid && tx_ready) nxt_first = 1'b0;
    nxt_wait = (svc_busy && !tx_valid) ? wait_ff + 1 : 0;
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_ff <= 1'b0;
      wait_ff  <= 0;
    end else begin
      first_ff <= nxt_first;
      wait_ff  <= nxt_wait;
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence s_held;
    tx_valid && $stable(tx_byte) && $stable(tx_last);
  endsequence
  chk_tx_hold: assert property (s_stall |=> s_held)
    else $error("reply byte not held");
  chk_abort_one: assert property (tx_abort |=> !tx_abort)
    else $error("abort longer than one cycle");
  chk_abort_when: assert property (tx_abort |->
    $past(rx_valid && rx_last, 2) || $past(rx_valid && rx_last, 3))
    else $error("abort not tied to end of request");
  chk_req_hold: assert property (cfg_req_valid && !cfg_req_ready |=>
    cfg_req_valid && $stable(cfg_req))
    else $error("target request dropped");
  chk_int_decode: assert property (cfg_req_valid |-> cfg_req.internal ==
    ((cfg_req.bus == 8'h00 && cfg_req.dev < 5'h08) ||
     (cfg_req.bus == 8'h01 && cfg_req.dev > 5'h07 && cfg_req.dev < 5'h10)))
    else $error("internal decode wrong");
  chk_loc_bus: assert property (cfg_req_valid && !cfg_req.downstream |->
    cfg_req.bus <= 8'h01)
    else $error("bad local bus forwarded");
  chk_ds_dword: assert property (cfg_req_valid && cfg_req.downstream |->
    cfg_req.rl == 8'h05)
    else $error("downstream size not dword");
  chk_first_cc: assert property (tx_valid && first_ff |-> tx_byte inside
    {8'h40, 8'h80, 8'h81, 8'h82, 8'h90, 8'h91})
    else $error("first reply byte not a completion code");
  chk_wait_bound: assert property (wait_ff <= WMAX)
    else $error("no reply within timeout");
endmodule

bind sideband_config_read_service sbcfg_chk #(
  .RSP_TIMEOUT_CYC(RSP_TIMEOUT_CYC)
) sbcfg_chk_inst (
  .core_clk, .rst_b, .frame_start, .frame_hdr, .rx_valid, .rx_byte, .rx_last,
  .rx_check_bad, .tx_valid, .tx_byte, .tx_last, .tx_ready, .tx_abort,
  .target_asleep, .ctrl_fault, .no_resources, .cfg_req_valid, .cfg_req,
  .cfg_req_ready, .cfg_rsp_valid, .cfg_rsp, .svc_busy
);

// ===== cfg_target_model.sv
module cfg_target_model
  import sbcfg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        cfg_req_valid,
  input  wire cfg_req_s    cfg_req,
  input  wire logic [7:0]  lat,
  input  wire rsp_status_e st,
  input  wire logic [31:0] dat,
  output logic             cfg_req_ready,
  output logic             cfg_rsp_valid,
  output cfg_rsp_s         cfg_rsp,
  output cfg_req_s         seen,
  output int               n_acc
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       pend;
  logic       hold;
  logic [7:0] cnt;
  // Odd latency also stalls acceptance one cycle
  assign cfg_req_ready = cfg_req_valid && !pend && (!lat[0] || hold);
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend <= 1'b0;
      hold <= 1'b0;
      cnt <= '0;
      n_acc <= 0;
      cfg_rsp_valid <= 1'b0;
      cfg_rsp <= '0;
      seen <= '0;
    end else begin
      hold <= cfg_req_valid && !cfg_req_ready;
      cfg_rsp_valid <= 1'b0;
      // Released data toggles so stale values never look valid
      cfg_rsp.data <= ~cfg_rsp.data;
      if (cfg_req_valid && cfg_req_ready) begin
        pend <= 1'b1;
        cnt <= lat;
        seen <= cfg_req;
        n_acc <= n_acc + 1;
      end else if (pend && cnt == 8'h00) begin
        pend <= 1'b0;
        cfg_rsp_valid <= 1'b1;
        cfg_rsp <= '{status: st, data: dat};
      end else if (pend) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// ===== tb.sv
`include "sbcfg_cfg.svh"
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb
  import sbcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, rst_b = 0, frame_start = 0, rx_valid = 0, rx_last = 0;
  logic rx_check_bad = 0, tx_ready = 0, target_asleep = 0, ctrl_fault = 0;
  logic no_resources = 0, tx_valid, tx_last, tx_abort, svc_busy;
  logic cfg_req_valid, cfg_req_ready, cfg_rsp_valid;
  logic [7:0] rx_byte = '0, tx_byte, m_lat = '0;
  logic [31:0] m_dat = '0;
  frame_hdr_s frame_hdr = '0;
  cfg_req_s cfg_req, seen;
  cfg_rsp_s cfg_rsp;
  rsp_status_e m_st = rsp_ok;
  int n_fail = 0, n_compared = 0, seed = 32'hcbff, cyc = 0, n_acc;
  logic [7:0] cc_tab [5] = '{8'h40, 8'h81, 8'h82, 8'h91, 8'h90};
  logic [15:0] cb [6] = '{16'h0007, 16'h0008, 16'h0107, 16'h0108, 16'h010f, 16'h0110};
  always #12.5 core_clk = ~core_clk;
  sideband_config_read_service #(.RSP_TIMEOUT_CYC(20)) sideband_config_read_service_inst (
    .core_clk, .rst_b, .frame_start, .frame_hdr, .rx_valid, .rx_byte, .rx_last,
    .rx_check_bad, .tx_valid, .tx_byte, .tx_last, .tx_ready, .tx_abort,
    .target_asleep, .ctrl_fault, .no_resources, .cfg_req_valid, .cfg_req,
    .cfg_req_ready, .cfg_rsp_valid, .cfg_rsp, .svc_busy);
  cfg_target_model cfg_target_model_inst (.core_clk, .rst_b, .cfg_req_valid,
    .cfg_req, .lat(m_lat), .st(m_st), .dat(m_dat), .cfg_req_ready,
    .cfg_rsp_valid, .cfg_rsp, .seen, .n_acc);
  // ------
  // Expectations
  // ------
  function automatic cfg_req_s exp_req(input logic [7:0] cmd, rl, input logic [31:0] a);
    cfg_req_s r;
    r.downstream = (cmd == `CMD_DS_RD);
    r.bus = r.downstream ? a[27:20] : {4'h0, a[23:20]};
    r.dev = a[19:15];
    r.func = a[14:12];
    r.offset = a[11:0];
    r.rl = rl;
    r.internal = (r.bus == 8'h00 && r.dev < 5'h08) ||
                 (r.bus == 8'h01 && r.dev > 5'h07 && r.dev < 5'h10);
    return r;
  endfunction
  function automatic logic [31:0] mask(input logic [7:0] rl, input logic [31:0] d);
    return (rl == 8'h02) ? {24'h0, d[7:0]} : (rl == 8'h03) ? {16'h0, d[15:0]} : d;
  endfunction
  // ------
  // Command driver and reply collector
  // ------
  task automatic run(input logic [7:0] cmd, wl, rl, input logic [31:0] a,
                     input logic [7:0] ecc, input logic [31:0] ed, input bit acc, ab, bad);
    logic [7:0] q[$];
    logic [31:0] md;
    logic got_ab, lst;
    int na, n0, k;
    na = (cmd == `CMD_DS_RD) ? 4 : 3;
    n0 = n_acc;
    md = mask(rl, ed);
    @(negedge core_clk);
    frame_start = 1'b1;
    frame_hdr = '{wl: wl, rl: rl};
    @(negedge core_clk);
    frame_start = 1'b0;
    for (k = 0; k < na + 2; k++) begin
      rx_valid = 1'b1;
      rx_last = (k == na + 1);
      rx_check_bad = bad && rx_last;
      rx_byte = (k == 0) ? cmd : (k == 1) ? 8'h00 : a[8*(k-2) +: 8];
      @(negedge core_clk);
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_check_bad = 1'b0;
    got_ab = 1'b0;
    lst = 1'b0;
    // Outputs settle between edges; a byte seen here with ready is taken at the next edge
    for (k = 0; k < 120 && !lst && !got_ab; k++) begin
      tx_ready = 1'($random(seed));
      if (tx_abort === 1'b1) got_ab = 1'b1;
      if (tx_valid === 1'b1 && tx_ready) begin
        q.push_back(tx_byte);
        lst = tx_last;
      end
      @(negedge core_clk);
    end
    tx_ready = 1'b0;
    for (k = 0; k < 20 && svc_busy !== 1'b0; k++) @(negedge core_clk);
    `CHK("abort", ab, got_ab)
    `CHK("count", (ab || bad) ? 0 : 32'(rl), q.size())
    if (!ab && !bad) `CHK("cc", ecc, q[0])
    if (!ab && !bad) `CHK("last", 1'b1, lst)
    `CHK("idle", 1'b0, svc_busy)
    for (k = 1; ecc == 8'h40 && k < q.size(); k++) `CHK("data", md[8*(k-1) +: 8], q[k])
    `CHK("access", n0 + 32'(acc), n_acc)
    if (acc) `CHK("request", exp_req(cmd, rl, a), seen)
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Ceiling far above the under 2000 cycles the sequence needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ------
  // Scenarios
  // ------
  initial begin
    logic [31:0] a;
    logic [7:0] rl;
    int i;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    m_dat = $random(seed);
    run(`CMD_LOC_RD, `WL_LOC_RD, `RL_DWORD, 32'h0010_8123, 8'h40, m_dat, 1, 0, 0);
    for (i = 0; i < 30; i++) begin
      a = $random(seed);
      m_lat = 8'({$random(seed)} % 9);
      m_dat = $random(seed);
      rl = (i % 3 == 0) ? `RL_BYTE : (i % 3 == 1) ? `RL_WORD : `RL_DWORD;
      a[31:28] = 4'h0;
      if (i % 2 == 0) run(`CMD_DS_RD, `WL_DS_RD, `RL_DWORD, a, 8'h40, m_dat, 1, 0, 0);
      else run(`CMD_LOC_RD, `WL_LOC_RD, rl, {11'h0, a[20:0]}, 8'h40, m_dat, 1, 0, 0);
    end
    m_dat = 32'hffff_ffff;
    for (i = 0; i < 6; i++) begin
      a = {4'h0, cb[i][15:8], cb[i][4:0], 15'h0a5c};
      run(`CMD_DS_RD, `WL_DS_RD, `RL_DWORD, a, 8'h40, m_dat, 1, 0, 0);
    end
    for (i = 1; i < 5; i++) begin
      m_st = rsp_status_e'(i);
      run(`CMD_DS_RD, `WL_DS_RD, `RL_DWORD, 32'h0300_0010, cc_tab[i], 0, 1, 0, 0);
    end
    m_st = rsp_ok;
    for (i = 0; i < 3; i++) begin
      {ctrl_fault, target_asleep, no_resources} = (i == 0) ? 3'b110 : (i == 1) ? 3'b011 : 3'b001;
      run(`CMD_LOC_RD, `WL_LOC_RD, `RL_WORD, 32'h0000_8000, cc_tab[3-i], 0, 0, 0, 0);
    end
    {ctrl_fault, target_asleep, no_resources} = 3'b000;
    run(`CMD_DS_RD, `WL_DS_RD, `RL_DWORD, 32'ha000_1000, 8'h90, 0, 0, 0, 0);
    run(`CMD_LOC_RD, `WL_LOC_RD, `RL_WORD, 32'h0020_9004, 8'h40, 0, 0, 0, 0);
    run(`CMD_DS_RD, `WL_DS_RD, `RL_BYTE, 32'h0, 8'h40, 0, 0, 1, 0);
    run(`CMD_LOC_RD, `WL_LOC_RD, 8'h04, 32'h0, 8'h40, 0, 0, 1, 0);
    run(`CMD_DS_RD, `WL_LOC_RD, `RL_DWORD, 32'h0, 8'h40, 0, 0, 1, 0);
    run(`CMD_LOC_RD, `WL_DS_RD, `RL_DWORD, 32'h0, 8'h40, 0, 0, 1, 0);
    run(8'h62, `WL_DS_RD, `RL_DWORD, 32'h0, 8'h40, 0, 0, 1, 0);
    m_lat = 8'd40;
    run(`CMD_DS_RD, `WL_DS_RD, `RL_DWORD, 32'h0050_0004, 8'h80, 0, 1, 0, 0);
    repeat (60) @(negedge core_clk);
    m_lat = 8'd0;
    run(`CMD_DS_RD, `WL_DS_RD, `RL_DWORD, 32'h0050_0008, 8'h40, 0, 0, 0, 1);
    wrap_up();
  end
endmodule
